// file: design/dcf_cfg.svh
// Purpose: constants of the 18-bit fifo with programmable level indicators
// Assumes: one clock drives both ports
// Notes:   offsets are byte addresses on the register bus
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH

`define DCF_WORD_W        18
`define DCF_OFF_W         12
`define DCF_DEPTH         13'h0400
`define DCF_HALF          13'h0200
`define DCF_PTR_W         10
`define DCF_CNT_W         13
`define DCF_OFF_EMPTY_RST 12'h07f
`define DCF_OFF_FULL_RST  12'h07f

`define DCF_REG_STATUS    4'h0
`define DCF_REG_CTRL      4'h4
`define DCF_REG_OFFSETS   4'h8
`define DCF_CTRL_CASCADE  0
`define DCF_CTRL_CLEAR    1
`define DCF_ST_EMPTY_N    16
`define DCF_ST_FULL_N     17
`define DCF_ST_NEMPTY_N   18
`define DCF_ST_NFULL_N    19
`define DCF_ST_HALF       20
`define DCF_OFFS_FULL_LSB 16

`endif

// file: design/dcf_pkg.sv
// Purpose: shared types of the fifo
// Assumes: nothing
// Notes:   constants live in dcf_cfg.svh
package dcf_pkg;
    typedef enum logic {OFF_SEL_EMPTY, OFF_SEL_FULL} dcf_offsel_t;
    typedef logic [17:0] dcf_word_t;
endpackage

// file: design/dcf_mem.sv
// Purpose: word storage with a registered read port
// Assumes: one write and one read per clock at most
// Notes:   the read register can also be loaded with an offset word
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_mem (
    // clock
    input  wire logic                  clk,
    // write side
    input  wire logic                  wrEn,
    input  wire logic [`DCF_PTR_W-1:0] wrAddr,
    input  wire dcf_pkg::dcf_word_t    wrData,
    // read side
    input  wire logic                  rdEn,
    input  wire logic [`DCF_PTR_W-1:0] rdAddr,
    input  wire logic                  ldEn,
    input  wire dcf_pkg::dcf_word_t    ldData,
    input  wire logic                  clrEn,
    output dcf_pkg::dcf_word_t         rdData
);
    dcf_pkg::dcf_word_t mem [0:`DCF_DEPTH-1];
    dcf_pkg::dcf_word_t rdData_r;

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // an idle or refused read keeps the last word on the outputs
    always_ff @(posedge clk) begin
        if (clrEn) begin
            rdData_r <= '0;
        end else if (rdEn) begin
            rdData_r <= mem[rdAddr];
        end else if (ldEn) begin
            rdData_r <= ldData;
        end
    end

    assign rdData = rdData_r;
endmodule

// file: design/dcf_avs.sv
// Purpose: avalon-mm slave for status, control and offset readback
// Assumes: master holds a request until waitrequest is low
// Notes:   one wait state on every access
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_avs (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // block side
    input  wire logic [31:0] statusWord,
    input  wire logic [31:0] offsetWord,
    output logic             cascadeEn,
    output logic             clearPulse
);
    logic        waitReq_r;
    logic [31:0] readData_r;
    logic        cascade_r;
    logic        clear_r;
    wire         reqSeen = (avs_read | avs_write) & waitReq_r;
    wire         wrStb   = avs_write & ~waitReq_r;
    wire         ctrlHit = (avs_address == `DCF_REG_CTRL);
    wire         ctrlWr  = wrStb & ctrlHit & avs_byteenable[0];
    wire [31:0]  rdMux   = (avs_address == `DCF_REG_STATUS)  ? statusWord :
                           (avs_address == `DCF_REG_OFFSETS) ? offsetWord :
                           ctrlHit ? {31'h00000000, cascade_r} : 32'h00000000;

    always_ff @(posedge clk) begin
        if (rst) begin
            waitReq_r  <= 1'b1;
            readData_r <= 32'h00000000;
            cascade_r  <= 1'b0;
            clear_r    <= 1'b0;
        end else begin
            waitReq_r  <= ~reqSeen;
            readData_r <= (reqSeen & avs_read) ? rdMux : readData_r;
            cascade_r  <= ctrlWr ? avs_writedata[`DCF_CTRL_CASCADE] : cascade_r;
            clear_r    <= ctrlWr & avs_writedata[`DCF_CTRL_CLEAR];
        end
    end

    assign avs_readdata    = readData_r;
    assign avs_waitrequest = waitReq_r;
    assign cascadeEn       = cascade_r;
    assign clearPulse      = clear_r;
endmodule

// file: design/dcf_fifo.sv
// Purpose: 18-bit fifo with programmable near-empty and near-full indicators
// Assumes: write and read ports share clk; pins synchronous to clk
// Notes:   cascade write and read chain pins are active-high one-cycle pulses
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_fifo (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // write port
    input  wire dcf_pkg::dcf_word_t dataIn,
    input  wire logic               write_enable_n,
    // read port
    input  wire logic               read_enable_n,
    input  wire logic               output_drive_n,
    output dcf_pkg::dcf_word_t      dataOut,
    output logic                    dataOutOe,
    // control pins
    input  wire logic               offset_access_n,
    input  wire logic               flag_sync_select,
    input  wire logic               device_reset_n,
    // level indicators
    output logic                    empty_indicator_n,
    output logic                    full_indicator_n,
    output logic                    near_empty_indicator_n,
    output logic                    near_full_indicator_n,
    // cascade chain
    input  wire logic               chain_head_or_replay,
    input  wire logic               chain_write_in,
    input  wire logic               chain_read_in,
    output logic                    chain_write_out_or_half_level,
    output logic                    chain_read_out,
    // avalon-mm
    input  wire logic [3:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest
);
    logic [`DCF_PTR_W-1:0] wrPtr_r;
    logic [`DCF_PTR_W-1:0] rdPtr_r;
    logic [`DCF_CNT_W-1:0] count_r;
    logic [`DCF_CNT_W-1:0] count_nxt;
    logic [`DCF_CNT_W-1:0] written_r;
    logic [`DCF_OFF_W-1:0] offEmpty_r;
    logic [`DCF_OFF_W-1:0] offFull_r;
    dcf_pkg::dcf_offsel_t  offSelW_r;
    dcf_pkg::dcf_offsel_t  offSelR_r;
    logic                  replayPrev_r;
    logic                  wrTok_r;
    logic                  rdTok_r;
    logic                  emptyN_r;
    logic                  fullN_r;
    logic                  nEmptyN_r;
    logic                  nFullN_r;
    logic                  chainWo_r;
    logic                  chainRo_r;
    logic                  oe_r;
    logic                  cascadeEn;
    logic                  clearPulse;

    // near-empty holds at or below n words, near-full from depth minus m
    function automatic logic nearEmpty(input logic [`DCF_CNT_W-1:0] c,
                                       input logic [`DCF_OFF_W-1:0] off);
        nearEmpty = (c <= {1'b0, off});
    endfunction

    function automatic logic nearFull(input logic [`DCF_CNT_W-1:0] c,
                                      input logic [`DCF_OFF_W-1:0] off);
        nearFull = (c >= (`DCF_DEPTH - {1'b0, off}));
    endfunction

    wire ldMode  = ~offset_access_n;
    wire wrReq   = ~write_enable_n;
    wire rdReq   = ~read_enable_n;
    wire clearIn = ~device_reset_n | clearPulse;
    wire isFull  = (count_r == `DCF_DEPTH);
    wire isEmpty = (count_r == {`DCF_CNT_W{1'b0}});
    wire wrOk    = wrReq & ~ldMode & ~isFull & wrTok_r;
    wire rdOk    = rdReq & ~ldMode & ~isEmpty & rdTok_r;
    wire ldWr    = wrReq & ldMode;
    wire ldRd    = rdReq & ldMode;
    wire replay  = ~cascadeEn & chain_head_or_replay & ~replayPrev_r;
    wire wrFills = cascadeEn & wrOk & (count_nxt == `DCF_DEPTH);
    wire rdDrain = cascadeEn & rdOk & (count_nxt == {`DCF_CNT_W{1'b0}});
    wire headDev = ~cascadeEn | ~chain_head_or_replay;

    // rewind counts everything written since reset, capped at the depth
    always_comb begin
        if (replay) begin
            count_nxt = written_r;
        end else begin
            count_nxt = count_r + {{(`DCF_CNT_W-1){1'b0}}, wrOk}
                                - {{(`DCF_CNT_W-1){1'b0}}, rdOk};
        end
    end

    wire [`DCF_CNT_W-1:0] nearSrc = flag_sync_select ? count_nxt : count_r;
    wire halfN  = ~(count_nxt > `DCF_HALF);
    wire [`DCF_OFF_W-1:0] offSel =
        (offSelR_r == dcf_pkg::OFF_SEL_EMPTY) ? offEmpty_r : offFull_r;
    wire dcf_pkg::dcf_word_t offWord = {6'h00, offSel};

    always_ff @(posedge clk) begin
        if (rst | clearIn) begin
            wrPtr_r   <= '0;
            rdPtr_r   <= '0;
            count_r   <= '0;
            written_r <= '0;
        end else begin
            wrPtr_r   <= wrOk ? wrPtr_r + 1'b1 : wrPtr_r;
            rdPtr_r   <= replay ? '0 : (rdOk ? rdPtr_r + 1'b1 : rdPtr_r);
            count_r   <= count_nxt;
            written_r <= (wrOk & (written_r != `DCF_DEPTH)) ? written_r + 1'b1
                                                             : written_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            offEmpty_r <= `DCF_OFF_EMPTY_RST;
            offFull_r  <= `DCF_OFF_FULL_RST;
        end else if (ldWr & (offSelW_r == dcf_pkg::OFF_SEL_EMPTY)) begin
            offEmpty_r <= dataIn[`DCF_OFF_W-1:0];
        end else if (ldWr) begin
            offFull_r  <= dataIn[`DCF_OFF_W-1:0];
        end
    end

    // sequence survives raising the load pin, so partial programming resumes
    always_ff @(posedge clk) begin
        if (rst | clearIn) begin
            offSelW_r <= dcf_pkg::OFF_SEL_EMPTY;
            offSelR_r <= dcf_pkg::OFF_SEL_EMPTY;
        end else begin
            offSelW_r <= ldWr ? dcf_pkg::dcf_offsel_t'(~offSelW_r) : offSelW_r;
            offSelR_r <= ldRd ? dcf_pkg::dcf_offsel_t'(~offSelR_r) : offSelR_r;
        end
    end

    // chain tokens: a received pulse wins over a simultaneous hand-off
    always_ff @(posedge clk) begin
        if (rst | clearIn) begin
            wrTok_r <= headDev;
            rdTok_r <= headDev;
        end else begin
            wrTok_r <= ~cascadeEn | chain_write_in | (wrTok_r & ~wrFills);
            rdTok_r <= ~cascadeEn | chain_read_in | (rdTok_r & ~rdDrain);
        end
    end

    always_ff @(posedge clk) begin
        if (rst | clearIn) begin
            emptyN_r     <= 1'b0;
            fullN_r      <= 1'b1;
            nEmptyN_r    <= 1'b0;
            nFullN_r     <= 1'b1;
            chainWo_r    <= ~cascadeEn;
            chainRo_r    <= 1'b0;
            replayPrev_r <= 1'b0;
        end else begin
            emptyN_r     <= (count_nxt != {`DCF_CNT_W{1'b0}});
            fullN_r      <= (count_nxt != `DCF_DEPTH);
            nEmptyN_r    <= ~nearEmpty(nearSrc, offEmpty_r);
            nFullN_r     <= ~nearFull(nearSrc, offFull_r);
            chainWo_r    <= cascadeEn ? wrFills : halfN;
            chainRo_r    <= rdDrain;
            replayPrev_r <= chain_head_or_replay;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= ~output_drive_n & rdTok_r;
        end
    end

    dcf_mem u_mem (
        .clk    (clk),
        .wrEn   (wrOk),
        .wrAddr (wrPtr_r),
        .wrData (dataIn),
        .rdEn   (rdOk),
        .rdAddr (rdPtr_r),
        .ldEn   (ldRd),
        .ldData (offWord),
        .clrEn  (rst | clearIn),
        .rdData (dataOut)
    );

    dcf_avs u_avs (
        .clk             (clk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .statusWord      ({11'h000, ~chainWo_r, nFullN_r, nEmptyN_r, fullN_r,
                           emptyN_r, 3'h0, count_r}),
        .offsetWord      ({4'h0, offFull_r, 4'h0, offEmpty_r}),
        .cascadeEn       (cascadeEn),
        .clearPulse      (clearPulse)
    );

    assign dataOutOe                     = oe_r;
    assign empty_indicator_n             = emptyN_r;
    assign full_indicator_n              = fullN_r;
    assign near_empty_indicator_n        = nEmptyN_r;
    assign near_full_indicator_n         = nFullN_r;
    assign chain_write_out_or_half_level = chainWo_r;
    assign chain_read_out                = chainRo_r;
endmodule

// file: tb/dcf_fifo_props.sv
// Purpose: concurrent checks on the fifo pins
// Assumes: one clock, rst synchronous active high
// Notes:   standalone use, chain inputs idle
`timescale 1ns/1ps
module dcf_fifo_props (
    // clock and reset
    input wire logic               clk,
    input wire logic               rst,
    // control pins
    input wire logic               read_enable_n,
    input wire logic               write_enable_n,
    input wire logic               output_drive_n,
    input wire logic               offset_access_n,
    input wire logic               device_reset_n,
    input wire logic               chain_head_or_replay,
    // outputs watched
    input wire dcf_pkg::dcf_word_t dataOut,
    input wire logic               dataOutOe,
    input wire logic               empty_indicator_n,
    input wire logic               full_indicator_n,
    input wire logic               near_empty_indicator_n,
    input wire logic               near_full_indicator_n,
    // bus
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic               avs_waitrequest
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // no device reset and no replay strobe at this edge
    sequence calm;
        device_reset_n && !chain_head_or_replay;
    endsequence
    sequence busAnswer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_empty_read_held: assert property (calm ##0 (!empty_indicator_n && !read_enable_n
        && offset_access_n) |=> $stable(dataOut)) else $error("read from empty moved data");
    a_reset_empties: assert property (!device_reset_n |=>
        !empty_indicator_n && full_indicator_n) else $error("device reset left words");
    a_drive_off: assert property (output_drive_n |=> !dataOutOe)
        else $error("outputs driven while released");
    a_full_holds: assert property (calm ##0 (!full_indicator_n && read_enable_n)
        |=> !full_indicator_n) else $error("full cleared without a read");
    a_write_fills: assert property (calm ##0 (!empty_indicator_n && !write_enable_n
        && offset_access_n) |=> empty_indicator_n) else $error("write into empty lost");
    a_near_empty_floor: assert property (!empty_indicator_n && $past(!empty_indicator_n)
        |-> !near_empty_indicator_n) else $error("near-empty high while empty");
    a_near_full_top: assert property (!full_indicator_n && $past(!full_indicator_n)
        |-> !near_full_indicator_n) else $error("near-full high while full");
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> busAnswer) else $error("bus answer not after one wait state");
endmodule

bind dcf_fifo dcf_fifo_props dcf_fifo_props_i (
    .clk(clk), .rst(rst), .read_enable_n(read_enable_n),
    .write_enable_n(write_enable_n), .output_drive_n(output_drive_n),
    .offset_access_n(offset_access_n), .device_reset_n(device_reset_n),
    .chain_head_or_replay(chain_head_or_replay), .dataOut(dataOut), .dataOutOe(dataOutOe),
    .empty_indicator_n(empty_indicator_n), .full_indicator_n(full_indicator_n),
    .near_empty_indicator_n(near_empty_indicator_n),
    .near_full_indicator_n(near_full_indicator_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// file: tb/dcf_peer.sv
// Purpose: producer model on the write port
// Assumes: bench raises wrGo for as many edges as words wanted
// Notes:   word sequence restarts on either reset
`timescale 1ns/1ps
module dcf_peer (
    // clock and reset
    input wire logic               clk,
    input wire logic               rst,
    // bench control
    input wire logic               wrGo,
    input wire dcf_pkg::dcf_word_t fixWord,
    // fifo side
    input wire logic               offset_access_n,
    input wire logic               device_reset_n,
    input wire logic               full_indicator_n,
    output logic                   write_enable_n,
    output dcf_pkg::dcf_word_t     dataIn
);
    logic [17:0]        seq_r;
    dcf_pkg::dcf_word_t word;
    initial begin
        write_enable_n = 1'b1;
        seq_r = 18'h00000;
    end
    assign word = seq_r ^ 18'h2a5a5;
    // no writes during or before reset
    always @(posedge clk) begin
        write_enable_n <= rst | ~device_reset_n | ~wrGo;
        if (rst || !device_reset_n) begin
            seq_r <= 18'h00000;
        end else if (!write_enable_n && offset_access_n && full_indicator_n) begin
            seq_r <= seq_r + 18'h00001;
        end
    end
    // idle bus shows the inverse, so a stale word never looks valid
    assign dataIn = !offset_access_n ? fixWord : (write_enable_n ? ~word : word);
endmodule

// file: tb/testbench.sv
// Purpose: self-checking bench of the fifo
// Assumes: standalone device, peer model writes counted words
// Notes:   offsets programmed to 4 and 5 before filling
`timescale 1ns/1ps
module testbench;
    logic               clk, rst, wrGo, read_enable_n, output_drive_n;
    logic               offset_access_n, flag_sync_select, device_reset_n, replay;
    logic               avs_read, avs_write, avs_waitrequest, write_enable_n, dataOutOe;
    logic               empty_n, full_n, nEmpty_n, nFull_n, half, chainRo;
    logic [3:0]         avs_address;
    logic [31:0]        avs_writedata, avs_readdata, q;
    dcf_pkg::dcf_word_t fixWord, dataIn, dataOut;
    int                 num_errors = 0, total_checks = 0;
    wire  [4:0]         flags = {full_n, nFull_n, half, nEmpty_n, empty_n};

    dcf_peer dcf_peer_i (.clk(clk), .rst(rst), .wrGo(wrGo), .fixWord(fixWord),
        .offset_access_n(offset_access_n), .device_reset_n(device_reset_n),
        .full_indicator_n(full_n), .write_enable_n(write_enable_n), .dataIn(dataIn));
    // chain write and read inputs tied low, head pin driven by replay, no next device on the read chain
    dcf_fifo dcf_fifo_i (.clk(clk), .rst(rst), .dataIn(dataIn),
        .write_enable_n(write_enable_n), .read_enable_n(read_enable_n),
        .output_drive_n(output_drive_n), .dataOut(dataOut), .dataOutOe(dataOutOe),
        .offset_access_n(offset_access_n), .flag_sync_select(flag_sync_select),
        .device_reset_n(device_reset_n), .empty_indicator_n(empty_n),
        .full_indicator_n(full_n), .near_empty_indicator_n(nEmpty_n),
        .near_full_indicator_n(nFull_n), .chain_head_or_replay(replay),
        .chain_write_in(1'b0), .chain_read_in(1'b0), .chain_write_out_or_half_level(half),
        .chain_read_out(chainRo), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic dcf_pkg::dcf_word_t pat(input int i);
        return 18'(i) ^ 18'h2a5a5;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // one wait state: answer sampled at the second edge
        check(n, 2);
    endtask

    task automatic wr(input int n, input dcf_pkg::dcf_word_t w);
        @(posedge clk);
        wrGo <= 1'b1;
        fixWord <= w;
        repeat (n) @(posedge clk);
        wrGo <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic rd(input int n, input int first);
        @(posedge clk);
        read_enable_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (i == n - 1) read_enable_n <= 1'b1;
            #1 check(dataOut, pat(first + i));
        end
    endtask

    task automatic t_offsets();
        @(posedge clk);
        offset_access_n <= 1'b0;
        wr(1, 18'h3f003);
        wr(1, 18'h00005);
        wr(1, 18'h00004);
        check(flags, 5'b11100);
        @(posedge clk);
        read_enable_n <= 1'b0;
        @(posedge clk);
        #1 check(dataOut, 18'h00004);
        @(posedge clk);
        read_enable_n <= 1'b1;
        #1 check(dataOut, 18'h00005);
        @(posedge clk);
        offset_access_n <= 1'b1;
        bus(1'b0, 4'h8, 32'h0);
        check(q, 32'h00050004);
    endtask

    task automatic t_fill();
        wr(4, 0);
        check(flags, 5'b11101);
        wr(1, 0);
        check(flags, 5'b11111);
        wr(508, 0);
        check(flags, 5'b11011);
        wr(505, 0);
        check(flags, 5'b11011);
        wr(1, 0);
        check(flags, 5'b10011);
        wr(7, 0);
        check(flags, 5'b00011);
        bus(1'b0, 4'h0, 32'h0);
        check(q[12:0], 13'h0400);
    endtask

    task automatic t_drain();
        @(posedge clk);
        output_drive_n <= 1'b0;
        rd(1024, 0);
        check(dataOutOe, 1'b1);
        rd(1, 1023);
        check(flags, 5'b11100);
        @(posedge clk);
        output_drive_n <= 1'b1;
        @(posedge clk);
        #1 check(dataOutOe, 1'b0);
    endtask

    task automatic t_devreset();
        wr(3, 0);
        @(posedge clk);
        device_reset_n <= 1'b0;
        @(posedge clk);
        device_reset_n <= 1'b1;
        @(posedge clk);
        #1 check(flags, 5'b11100);
        bus(1'b0, 4'h8, 32'h0);
        check(q, 32'h00050004);
    endtask

    task automatic t_replay();
        @(posedge clk);
        flag_sync_select <= 1'b1;
        wr(5, 0);
        rd(2, 0);
        @(posedge clk);
        replay <= 1'b1;
        @(posedge clk);
        replay <= 1'b0;
        // 3 words before the rewind, 5 after: near-empty must already be high
        #1 check(flags, 5'b11111);
        rd(5, 0);
    endtask

    task automatic t_bus();
        bus(1'b0, 4'hc, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 4'h4, 32'h1);
        bus(1'b0, 4'h4, 32'h0);
        check(q, 32'h1);
        check(half, 1'b0);
        wr(1, 0);
        rd(1, 5);
        check(chainRo, 1'b1);
        bus(1'b1, 4'h4, 32'h0);
        wr(3, 0);
        bus(1'b1, 4'h4, 32'h2);
        @(posedge clk);
        #1 check(flags, 5'b11100);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #160000;
        num_errors++;
        results();
    end

    initial begin
        {rst, read_enable_n, output_drive_n, offset_access_n, device_reset_n} = 5'h1f;
        {wrGo, flag_sync_select, replay, avs_read, avs_write} = 5'h00;
        {avs_address, avs_writedata, fixWord} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check({flags, dataOutOe, avs_waitrequest}, 7'b1110001);
        t_offsets();
        t_fill();
        t_drain();
        t_devreset();
        t_replay();
        t_bus();
        results();
    end
endmodule
